// file: pic_top.sv
// priority interrupt controller: priority fields per source, level and
// number arbitration, vector and fast-vector forming, wake to the clock
// unit and the register port.
// assumes all inputs are synchronous to CLOCK and that the core pulses
// IRQ_ACK when it takes the presented request.
`timescale 1ns/1ps
module pic_top
  import pic_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [PIC_RAW-1:0] REG_ADDR,
  input wire logic [PIC_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [PIC_DW-1:0] REG_RDATA,
  input wire logic [PIC_NSRC-1:0] IRQ_IN,
  input wire logic EXT_REQ_A_N,
  input wire logic EXT_REQ_B_N,
  input wire logic WAIT_MODE,
  input wire logic STOP_MODE,
  input wire logic IRQ_ACK,
  input wire logic EXC_DONE,
  output logic IRQ_REQ,
  output logic FAST_IRQ,
  output logic [1:0] REQ_LEVEL,
  output logic [PIC_VW-1:0] VECTOR_NUM,
  output logic [PIC_AW-1:0] VECTOR_ADDR,
  output logic [1:0] CURRENT_PRIORITY_CODE,
  output logic WAKE_REQ,
  output logic BOOT_FETCH
);

  logic rst_meta;
  logic rst_n;
  logic [PIC_DW-1:0] prio [PIC_NPRIO];
  logic [PIC_DW-1:0] vector_base;
  logic [PIC_DW-1:0] fast_match [2];
  logic [PIC_DW-1:0] fast_vector_low [2];
  logic [PIC_DW-1:0] fast_vector_high [2];
  logic edge_a;
  logic edge_b;
  logic ext_a_q;
  logic ext_b_q;
  logic latch_a;
  logic latch_b;
  logic ext_a_req;
  logic ext_b_req;
  logic low_power;
  logic lp_q;
  logic [PIC_NSRC-1:0] en_snap;
  logic [PIC_NSRC-1:0] pend;
  logic [PIC_NSRC-1:0] src_en;
  logic [1:0] src_lvl [PIC_NSRC];
  logic [PIC_NSRC-1:0] wake_mask;
  logic next_wake;
  logic win_valid;
  logic [PIC_VW-1:0] win_num;
  logic [1:0] win_lvl;
  logic hit0;
  logic hit1;
  pic_req_s next_pres;
  pic_req_s pres;
  pic_state_e state;
  logic [1:0] cur_code;
  logic [1:0] prev_code;
  logic boot;
  logic taken;
  logic [PIC_DW-1:0] rd_val;
  logic [PIC_DW*PIC_NPEND-1:0] pend_words;
  logic [PIC_RAW-1:0] pend_idx;

  // reset release through two flops
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // per-source enable and level: fixed sources always on at level 3, the rest from the priority fields
  for (genvar s = 0; s < PIC_NSRC; s++) begin : g_src
    if (s < PIC_NFIXED) begin : g_fix
      assign src_en[s] = 1'b1;
      assign src_lvl[s] = PIC_LVL_FIXED;
    end else if (s <= PIC_DBG_HI) begin : g_dbg
      localparam int RI = (s < PIC_DBG1_LO) ? 0 : 1;
      localparam int LO = (s < PIC_DBG1_LO) ? (12 - 2 * (s - PIC_DBG_LO))
                                            : (4 - 2 * (s - PIC_DBG1_LO));
      logic [1:0] fld;
      assign fld = prio[RI][LO+1:LO];
      assign src_en[s] = fld != PIC_FLD_OFF;
      assign src_lvl[s] = fld;
    end else begin : g_ord
      localparam int K = s - PIC_ORD_LO;
      localparam int RI = 2 + K / PIC_FLD_PER_REG;
      localparam int LO = 14 - 2 * (K % PIC_FLD_PER_REG);
      logic [1:0] fld;
      assign fld = prio[RI][LO+1:LO];
      assign src_en[s] = fld != PIC_FLD_OFF;
      assign src_lvl[s] = fld - 2'h1;
    end
  end

  // external request pins: falling edge latched, or low level
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ext_a_q <= 1'b1;
      ext_b_q <= 1'b1;
      latch_a <= 1'b0;
      latch_b <= 1'b0;
    end else begin
      ext_a_q <= EXT_REQ_A_N;
      ext_b_q <= EXT_REQ_B_N;
      // a new edge beats the clear on acceptance
      if (edge_a && ext_a_q && !EXT_REQ_A_N) latch_a <= 1'b1;
      else if (taken && pres.vnum == 7'(PIC_EXT_A_SRC)) latch_a <= 1'b0;
      if (edge_b && ext_b_q && !EXT_REQ_B_N) latch_b <= 1'b1;
      else if (taken && pres.vnum == 7'(PIC_EXT_B_SRC)) latch_b <= 1'b0;
    end
  end

  // in low power no clock sees an edge, so request a follows the level
  assign ext_a_req = (edge_a && !low_power) ? latch_a : !EXT_REQ_A_N;
  assign ext_b_req = edge_b ? latch_b : !EXT_REQ_B_N;
  assign pend = IRQ_IN | (PIC_NSRC'(ext_a_req) << PIC_EXT_A_SRC)
                       | (PIC_NSRC'(ext_b_req) << PIC_EXT_B_SRC);

  // highest permitted level, then lowest number; last hit wins
  always_comb begin
    win_valid = 1'b0;
    win_num = '0;
    win_lvl = '0;
    for (int l = 0; l < 4; l++) begin
      for (int s = PIC_NSRC - 1; s >= 0; s--) begin
        if (pend[s] && src_en[s] && src_lvl[s] == 2'(l) &&
            2'(l) >= cur_code) begin
          win_valid = 1'b1;
          win_num = 7'(s);
          win_lvl = 2'(l);
        end
      end
    end
  end

  // fast match and address forming
  assign hit0 = win_lvl == PIC_LVL_FAST && win_num == fast_match[0][6:0];
  assign hit1 = win_lvl == PIC_LVL_FAST && win_num == fast_match[1][6:0];
  always_comb begin
    next_pres.valid = 1'b1;
    next_pres.fast = hit0 || hit1;
    next_pres.level = win_lvl;
    next_pres.vnum = win_num;
    if (hit0) begin
      next_pres.addr = {fast_vector_high[0][PIC_FVH_W-1:0],
                        fast_vector_low[0]};
    end else if (hit1) begin
      next_pres.addr = {fast_vector_high[1][PIC_FVH_W-1:0],
                        fast_vector_low[1]};
    end else begin
      next_pres.addr = {vector_base[PIC_BASE_W-1:0], win_num};
    end
  end

  assign taken = state == PIC_SHOW && IRQ_ACK;

  // presentation to the core; frozen from show until accepted
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state <= PIC_IDLE;
      pres <= PIC_REQ_RST;
    end else begin
      unique case (state)
        PIC_IDLE: begin
          if (win_valid && !boot) begin
            pres <= next_pres;
            state <= PIC_SHOW;
          end
        end
        PIC_SHOW: begin
          if (IRQ_ACK) begin
            pres.valid <= 1'b0;
            state <= PIC_GAP;
          end
        end
        PIC_GAP: state <= PIC_IDLE;
        default: state <= PIC_IDLE;
      endcase
    end
  end

  // current level code with one saved level for the return
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cur_code <= PIC_CODE_NONE;
      prev_code <= PIC_CODE_NONE;
    end else if (taken) begin
      prev_code <= cur_code;
      cur_code <= pic_code(pres.level);
    end else if (EXC_DONE) begin
      cur_code <= prev_code;
      prev_code <= PIC_CODE_NONE;
    end
  end

  // one boot cycle showing the first fetch address
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) boot <= 1'b1;
    else boot <= 1'b0;
  end

  // wake: snapshot of enables taken at entry into low power
  assign low_power = WAIT_MODE || STOP_MODE;
  assign wake_mask = STOP_MODE ? PIC_STOP_WAKE_MASK : '1;
  // the entry cycle still holds the snapshot of an earlier low-power
  // spell, so wake is only judged once the new snapshot has been taken
  assign next_wake = low_power && lp_q &&
                     |(pend & en_snap & wake_mask);
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      lp_q <= 1'b0;
      en_snap <= '0;
      WAKE_REQ <= 1'b0;
    end else begin
      lp_q <= low_power;
      if (low_power && !lp_q) en_snap <= src_en;
      WAKE_REQ <= next_wake;
    end
  end

  // register writes; read-only and unmapped offsets ignore writes
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PIC_NPRIO; i++) prio[i] <= PIC_PRIO_RST;
      vector_base <= PIC_VBASE_RST;
      for (int i = 0; i < 2; i++) begin
        fast_match[i] <= PIC_FAST_RST;
        fast_vector_low[i] <= PIC_FAST_RST;
        fast_vector_high[i] <= PIC_FAST_RST;
      end
      edge_a <= PIC_CTL_RST[PIC_CTL_EDGE_A];
      edge_b <= PIC_CTL_RST[PIC_CTL_EDGE_B];
    end else if (REG_WR) begin
      if (REG_ADDR == PIC_OFS_PRIO0)
        prio[0] <= REG_WDATA & PIC_PRIO0_WMASK;
      else if (REG_ADDR == PIC_OFS_PRIO0 + 5'h01)
        prio[1] <= REG_WDATA & PIC_PRIO1_WMASK;
      else if (REG_ADDR <= PIC_OFS_PRIO9)
        prio[4'(REG_ADDR)] <= REG_WDATA & PIC_PRIO_WMASK;
      case (REG_ADDR)
        PIC_OFS_VBASE: vector_base <= REG_WDATA & PIC_VBASE_WMASK;
        PIC_OFS_FM0: fast_match[0] <= REG_WDATA & PIC_FM_WMASK;
        PIC_OFS_FVL0: fast_vector_low[0] <= REG_WDATA;
        PIC_OFS_FVH0: fast_vector_high[0] <= REG_WDATA & PIC_FVH_WMASK;
        PIC_OFS_FM1: fast_match[1] <= REG_WDATA & PIC_FM_WMASK;
        PIC_OFS_FVL1: fast_vector_low[1] <= REG_WDATA;
        PIC_OFS_FVH1: fast_vector_high[1] <= REG_WDATA & PIC_FVH_WMASK;
        PIC_OFS_CTRL: begin
          edge_a <= REG_WDATA[PIC_CTL_EDGE_A];
          edge_b <= REG_WDATA[PIC_CTL_EDGE_B];
        end
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  assign pend_words = {(PIC_DW * PIC_NPEND - PIC_NSRC)'(0), pend};
  assign pend_idx = REG_ADDR - PIC_OFS_PEND0;
  always_comb begin
    rd_val = '0;
    if (REG_ADDR <= PIC_OFS_PRIO9) begin
      rd_val = prio[4'(REG_ADDR)];
    end else if (REG_ADDR >= PIC_OFS_PEND0 && REG_ADDR <= PIC_OFS_PEND5) begin
      rd_val = pend_words[PIC_DW * 32'(pend_idx) +: PIC_DW];
    end else begin
      case (REG_ADDR)
        PIC_OFS_VBASE: rd_val = vector_base;
        PIC_OFS_FM0: rd_val = fast_match[0];
        PIC_OFS_FVL0: rd_val = fast_vector_low[0];
        PIC_OFS_FVH0: rd_val = fast_vector_high[0];
        PIC_OFS_FM1: rd_val = fast_match[1];
        PIC_OFS_FVL1: rd_val = fast_vector_low[1];
        PIC_OFS_FVH1: rd_val = fast_vector_high[1];
        PIC_OFS_CTRL: begin
          rd_val[PIC_CTL_REQ] = pres.valid;
          rd_val[PIC_CTL_CODE_LO +: 2] = cur_code;
          rd_val[PIC_CTL_VNUM_LO +: PIC_VW] = pres.vnum;
          rd_val[PIC_CTL_WAKE] = WAKE_REQ;
          rd_val[PIC_CTL_EDGE_B] = edge_b;
          rd_val[PIC_CTL_EDGE_A] = edge_a;
        end
        default: rd_val = '0;
      endcase
    end
  end

  // read data registered, held until the next read
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) REG_RDATA <= '0;
    else if (REG_RD) REG_RDATA <= rd_val;
  end

  // outputs straight from the presentation, current level code and boot flops
  assign IRQ_REQ = pres.valid;
  assign FAST_IRQ = pres.fast;
  assign REQ_LEVEL = pres.level;
  assign VECTOR_NUM = pres.vnum;
  assign VECTOR_ADDR = pres.addr;
  assign CURRENT_PRIORITY_CODE = cur_code;
  assign BOOT_FETCH = boot;

  // checks on the block's own outputs
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  a_reserved_zero: assert property (
    REG_RD && REG_ADDR == PIC_OFS_PRIO0 |=>
    (REG_RDATA & ~PIC_PRIO0_WMASK) == 16'h0000)
    else $error("reserved priority bits read nonzero");
  a_hold_vector: assert property (
    IRQ_REQ && !IRQ_ACK |=>
    IRQ_REQ && $stable(VECTOR_ADDR) && $stable(REQ_LEVEL))
    else $error("presented request changed before acceptance");
  a_winner_shown: assert property (
    state == PIC_IDLE && win_valid && !boot
    |=> IRQ_REQ && VECTOR_NUM == $past(win_num))
    else $error("arbitration winner not presented");
  a_normal_addr: assert property (
    IRQ_REQ && !FAST_IRQ |->
    VECTOR_ADDR == {vector_base[PIC_BASE_W-1:0], VECTOR_NUM})
    else $error("normal vector address wrong");
  a_fast_addr: assert property (
    IRQ_REQ && FAST_IRQ |-> REQ_LEVEL == 2'h2
    && (VECTOR_ADDR == {fast_vector_high[0][4:0], fast_vector_low[0]} ||
        VECTOR_ADDR == {fast_vector_high[1][4:0], fast_vector_low[1]}))
    else $error("fast request without level 2 or pair address");
  a_code_on_ack: assert property (
    taken |=> CURRENT_PRIORITY_CODE == pic_code($past(REQ_LEVEL)))
    else $error("current level code not updated on acceptance");
  a_wake_follow: assert property (next_wake |=> WAKE_REQ)
    else $error("wake not raised for pending enabled request");
  a_wake_lowpower: assert property (WAKE_REQ |-> $past(low_power))
    else $error("wake raised outside low power");
  a_ext_a_level: assert property (
    lp_q && low_power && !EXT_REQ_A_N && en_snap[PIC_EXT_A_SRC]
    |=> WAKE_REQ)
    else $error("low level on request a did not wake");
  a_stop_filter: assert property (
    WAKE_REQ && $past(STOP_MODE) |->
    $past(|(pend & en_snap & PIC_STOP_WAKE_MASK)))
    else $error("stop wake from a source not allowed");
  a_boot_addr: assert property (
    $rose(rst_n) |-> BOOT_FETCH && VECTOR_ADDR == PIC_RESET_ADDR
    ##1 !BOOT_FETCH)
    else $error("boot fetch address not shown once");

  c_fast_taken: cover property (IRQ_REQ && FAST_IRQ ##[1:4] IRQ_ACK);
  c_nested: cover property (taken ##[1:20] IRQ_REQ && REQ_LEVEL == 2'h3);
  c_stop_wake: cover property (STOP_MODE && WAKE_REQ);
  c_boot: cover property ($rose(rst_n));

endmodule : pic_top

// file: pic_pkg.sv
// package for the priority interrupt controller: register map, field
// layout, reset values, presentation states and the request carrier.
// assumes a 16-bit peripheral register port addressed by word offset.
package pic_pkg;

  // source population and numbering
  localparam int PIC_NSRC = 82;
  localparam int PIC_NFIXED = 13;
  localparam int PIC_DBG_LO = 13;
  localparam int PIC_DBG1_LO = 15;
  localparam int PIC_DBG_HI = 17;
  localparam int PIC_ORD_LO = 18;
  localparam int PIC_EXT_A_SRC = 18;
  localparam int PIC_EXT_B_SRC = 19;
  localparam int PIC_CAN_SRC = 20;
  localparam int PIC_FLD_PER_REG = 8;

  // widths
  localparam int PIC_DW = 16;
  localparam int PIC_RAW = 5;
  localparam int PIC_VW = 7;
  localparam int PIC_AW = 21;
  localparam int PIC_BASE_W = 14;
  localparam int PIC_FVH_W = 5;
  localparam int PIC_NPRIO = 10;
  localparam int PIC_NPEND = 6;

  // register offsets (word offsets on the register port)
  localparam logic [4:0] PIC_OFS_PRIO0 = 5'h00;
  localparam logic [4:0] PIC_OFS_PRIO9 = 5'h09;
  localparam logic [4:0] PIC_OFS_VBASE = 5'h0a;
  localparam logic [4:0] PIC_OFS_FM0 = 5'h0b;
  localparam logic [4:0] PIC_OFS_FVL0 = 5'h0c;
  localparam logic [4:0] PIC_OFS_FVH0 = 5'h0d;
  localparam logic [4:0] PIC_OFS_FM1 = 5'h0e;
  localparam logic [4:0] PIC_OFS_FVL1 = 5'h0f;
  localparam logic [4:0] PIC_OFS_FVH1 = 5'h10;
  localparam logic [4:0] PIC_OFS_PEND0 = 5'h11;
  localparam logic [4:0] PIC_OFS_PEND5 = 5'h16;
  localparam logic [4:0] PIC_OFS_CTRL = 5'h1d;

  // writable bit masks; everything else reads zero, apart from the pending words and the status fields of the control register
  localparam logic [15:0] PIC_PRIO0_WMASK = 16'h3c00;
  localparam logic [15:0] PIC_PRIO1_WMASK = 16'h003f;
  localparam logic [15:0] PIC_PRIO_WMASK = 16'hffff;
  localparam logic [15:0] PIC_VBASE_WMASK = 16'h3fff;
  localparam logic [15:0] PIC_FM_WMASK = 16'h007f;
  localparam logic [15:0] PIC_FVH_WMASK = 16'h001f;
  localparam logic [15:0] PIC_CTL_WMASK = 16'h0003;

  // reset values
  localparam logic [15:0] PIC_PRIO_RST = 16'h0000;
  localparam logic [15:0] PIC_VBASE_RST = 16'h0000;
  localparam logic [15:0] PIC_FAST_RST = 16'h0000;
  localparam logic [15:0] PIC_CTL_RST = 16'h0000;

  // control register fields
  localparam int PIC_CTL_REQ = 15;
  localparam int PIC_CTL_CODE_LO = 13;
  localparam int PIC_CTL_VNUM_LO = 6;
  localparam int PIC_CTL_WAKE = 5;
  localparam int PIC_CTL_EDGE_B = 1;
  localparam int PIC_CTL_EDGE_A = 0;

  // levels and current-level codes
  localparam logic [1:0] PIC_LVL_FAST = 2'h2;
  localparam logic [1:0] PIC_LVL_FIXED = 2'h3;
  localparam logic [1:0] PIC_FLD_OFF = 2'h0;
  localparam logic [1:0] PIC_CODE_NONE = 2'h0;
  localparam logic [1:0] PIC_CODE_L0 = 2'h1;
  localparam logic [1:0] PIC_CODE_L1 = 2'h2;
  localparam logic [1:0] PIC_CODE_L23 = 2'h3;

  // sources allowed to wake from stop
  localparam logic [PIC_NSRC-1:0] PIC_STOP_WAKE_MASK =
    (PIC_NSRC'(1) << PIC_CAN_SRC) | (PIC_NSRC'(1) << PIC_EXT_A_SRC) |
    (PIC_NSRC'(1) << PIC_EXT_B_SRC);

  // first fetch address after reset
  localparam logic [PIC_AW-1:0] PIC_RESET_ADDR =
    {PIC_VBASE_RST[PIC_BASE_W-1:0], 7'h00};

  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_SHOW = 2'b01,
    PIC_GAP = 2'b11
  } pic_state_e;

  typedef struct packed {
    logic valid;
    logic fast;
    logic [1:0] level;
    logic [PIC_VW-1:0] vnum;
    logic [PIC_AW-1:0] addr;
  } pic_req_s;

  localparam pic_req_s PIC_REQ_RST = '{1'b0, 1'b0, 2'h0, 7'h00,
                                       PIC_RESET_ADDR};

  // code reported for an accepted level
  function automatic logic [1:0] pic_code(input logic [1:0] level);
    logic [1:0] c;
    c = PIC_CODE_L23;
    if (level == 2'h0) c = PIC_CODE_L0;
    else if (level == 2'h1) c = PIC_CODE_L1;
    return c;
  endfunction : pic_code

endpackage : pic_pkg

// file: pic_core_model.sv
// core-side partner of the interrupt controller: takes a presented request
// and answers with a one-cycle acknowledge after a chosen number of cycles.
// assumes the design holds its request until the acknowledge is sampled.
`timescale 1ns/1ps
module pic_core_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic irq_req,
  input wire logic [3:0] ack_wait,
  output logic irq_ack
);
  logic [3:0] cnt;

  // the controller gates by level itself, so every request is taken; the
  // core would check the fetched word here before fast handling
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (irq_req && !irq_ack && cnt >= ack_wait) begin
      irq_ack <= 1'b1;
      cnt <= 4'h0;
    end else begin
      irq_ack <= 1'b0;
      cnt <= (irq_req && !irq_ack) ? cnt + 4'h1 : 4'h0;
    end
  end

endmodule : pic_core_model

// file: pic_top_tb_top.sv
// self-checking bench for the interrupt controller: register map, level
// and number arbitration, nesting codes, fast vectors and wake requests.
// assumes the core model acknowledges each presented request.
`timescale 1ns/1ps
module pic_top_tb_top;
  import pic_pkg::*;
  logic CLOCK, RESETN, REG_WR, REG_RD, EXT_REQ_A_N, EXT_REQ_B_N;
  logic WAIT_MODE, STOP_MODE, IRQ_ACK, EXC_DONE, IRQ_REQ, FAST_IRQ;
  logic WAKE_REQ, BOOT_FETCH;
  logic [PIC_RAW-1:0] REG_ADDR;
  logic [PIC_DW-1:0] REG_WDATA, REG_RDATA, rv;
  logic [PIC_NSRC-1:0] IRQ_IN;
  logic [1:0] REQ_LEVEL, CURRENT_PRIORITY_CODE;
  logic [PIC_VW-1:0] VECTOR_NUM;
  logic [PIC_AW-1:0] VECTOR_ADDR;
  logic [3:0] ack_wait;
  int err_total, checks, cyc;
  logic [4:0] t_ofs [0:7] = '{5'h00, 5'h01, 5'h02, 5'h0a, 5'h0b, 5'h0d,
                              5'h11, 5'h17};
  logic [15:0] t_msk [0:7] = '{16'h3c00, 16'h003f, 16'hffff, 16'h3fff,
                               16'h007f, 16'h001f, 16'h0000, 16'h0000};

  pic_top dut (.CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .IRQ_IN(IRQ_IN), .EXT_REQ_A_N(EXT_REQ_A_N),
    .EXT_REQ_B_N(EXT_REQ_B_N), .WAIT_MODE(WAIT_MODE),
    .STOP_MODE(STOP_MODE), .IRQ_ACK(IRQ_ACK), .EXC_DONE(EXC_DONE),
    .IRQ_REQ(IRQ_REQ), .FAST_IRQ(FAST_IRQ), .REQ_LEVEL(REQ_LEVEL),
    .VECTOR_NUM(VECTOR_NUM), .VECTOR_ADDR(VECTOR_ADDR),
    .CURRENT_PRIORITY_CODE(CURRENT_PRIORITY_CODE), .WAKE_REQ(WAKE_REQ),
    .BOOT_FETCH(BOOT_FETCH));
  pic_core_model core (.clock(CLOCK), .reset_n(RESETN), .irq_req(IRQ_REQ),
    .ack_wait(ack_wait), .irq_ack(IRQ_ACK));

  // clock and hang guard
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask : wr

  // read data is registered at the edge that samples the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask : rd

  task automatic step(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : step

  // waits for a presentation, checks it, drops the source at the ack edge
  task automatic take(input int num, input logic [1:0] lvl,
      input logic fast, input logic [20:0] addr, input logic done);
    int n;
    n = 0;
    while (IRQ_REQ !== 1'b1 && n < 60) begin
      step(1);
      n++;
    end
    chk("req", 1, IRQ_REQ);
    chk("num", num, VECTOR_NUM);
    chk("lvl", lvl, REQ_LEVEL);
    chk("fast", fast, FAST_IRQ);
    chk("addr", addr, VECTOR_ADDR);
    while (IRQ_ACK !== 1'b1 && n < 80) begin
      step(1);
      n++;
      chk("held", num, VECTOR_NUM);
    end
    @(posedge CLOCK);
    IRQ_IN[num] <= 1'b0;
    if (done) begin
      @(posedge CLOCK);
      EXC_DONE <= 1'b1;
      @(posedge CLOCK);
      EXC_DONE <= 1'b0;
    end
  endtask : take

  function automatic logic [20:0] va(input int n);
    return {14'h0123, 7'(n)};
  endfunction : va

  initial begin
    {RESETN, REG_WR, REG_RD, WAIT_MODE, STOP_MODE, EXC_DONE} = '0;
    {EXT_REQ_A_N, EXT_REQ_B_N} = 2'b11;
    REG_ADDR = '0;
    REG_WDATA = '0;
    IRQ_IN = '0;
    ack_wait = 4'h0;
    err_total = 0;
    checks = 0;
    cyc = 0;
    step(16);
    chk("boot", 1, BOOT_FETCH);
    chk("boot_addr", 0, VECTOR_ADDR);
    @(posedge CLOCK);
    RESETN <= 1'b1;
    step(4);
    chk("boot_end", 0, BOOT_FETCH);
    // reset values across the whole map, unmapped offsets included
    for (int a = 0; a < 32; a++) begin
      rd(5'(a), rv);
      chk("reset_val", 0, rv);
    end
    // reserved bits and read-only places ignore writes
    for (int i = 0; i < 8; i++) begin
      wr(t_ofs[i], 16'hffff);
      rd(t_ofs[i], rv);
      chk("wmask", t_msk[i], rv);
      wr(t_ofs[i], 16'h0000);
    end
    // software sets up levels, vector base and fast pair 1
    wr(5'h0a, 16'h0123);
    wr(5'h02, 16'h0001);
    wr(5'h03, 16'hc040);
    wr(5'h00, 16'h1000);
    wr(5'h0e, 16'h001a);
    wr(5'h0f, 16'h1234);
    wr(5'h10, 16'h0015);
    // fixed level first, then lowest number; nesting code blocks level 0
    @(posedge CLOCK);
    IRQ_IN[5] <= 1'b1;
    IRQ_IN[25] <= 1'b1;
    IRQ_IN[30] <= 1'b1;
    ack_wait <= 4'h6;
    take(5, 2'h3, 1'b0, va(5), 1'b1);
    take(25, 2'h0, 1'b0, va(25), 1'b0);
    #1 chk("code", 1, CURRENT_PRIORITY_CODE);
    rd(5'h12, rv);
    chk("pending", 16'h4000, rv);
    chk("nest_block", 0, IRQ_REQ);
    // control word: code 01, last presented number 25, no request
    rd(5'h1d, rv);
    chk("ctrl", 16'h2640, rv);
    @(posedge CLOCK);
    EXC_DONE <= 1'b1;
    @(posedge CLOCK);
    EXC_DONE <= 1'b0;
    ack_wait <= 4'h0;
    take(30, 2'h0, 1'b0, va(30), 1'b1);
    // fast vector at level 2 beats debug source at level 1
    @(posedge CLOCK);
    IRQ_IN[13] <= 1'b1;
    IRQ_IN[26] <= 1'b1;
    take(26, 2'h2, 1'b1, 21'h151234, 1'b1);
    take(13, 2'h1, 1'b0, va(13), 1'b1);
    // wait: only sources enabled at entry wake the clocks
    @(posedge CLOCK);
    WAIT_MODE <= 1'b1;
    wr(5'h04, 16'h0001);
    @(posedge CLOCK);
    IRQ_IN[41] <= 1'b1;
    step(3);
    chk("wake_late", 0, WAKE_REQ);
    @(posedge CLOCK);
    IRQ_IN[30] <= 1'b1;
    step(3);
    chk("wake_wait", 1, WAKE_REQ);
    @(posedge CLOCK);
    {IRQ_IN[30], IRQ_IN[41], WAIT_MODE} <= 3'b000;
    // stop: clocked peripherals cannot wake, external a at low level can
    wr(5'h04, 16'h0004);
    wr(5'h02, 16'h4001);
    wr(5'h1d, 16'h0001);
    @(posedge CLOCK);
    STOP_MODE <= 1'b1;
    @(posedge CLOCK);
    IRQ_IN[40] <= 1'b1;
    step(3);
    chk("wake_stop", 0, WAKE_REQ);
    @(posedge CLOCK);
    EXT_REQ_A_N <= 1'b0;
    step(3);
    chk("wake_ext_a", 1, WAKE_REQ);
    // pin released in stop: a level input drops, an edge latch would not
    @(posedge CLOCK);
    EXT_REQ_A_N <= 1'b1;
    step(2);
    chk("wake_drop", 0, WAKE_REQ);
    rd(5'h12, rv);
    chk("ext_a_level", 16'h0000, rv);
    // back in normal mode the latched edge is served, then cleared
    @(posedge CLOCK);
    {IRQ_IN[40], STOP_MODE, EXC_DONE} <= 3'b001;
    @(posedge CLOCK);
    EXC_DONE <= 1'b0;
    take(18, 2'h0, 1'b0, va(18), 1'b1);
    rd(5'h12, rv);
    chk("ext_a_clear", 16'h0000, rv);
    report_and_stop();
  end
endmodule : pic_top_tb_top
